// [bench/drs_capture_model.sv]
// Far-side capture logic that latches both ports on each data-valid clock rise.
// Assumes port data settle within 1 ns of the rising data-valid edge.
`timescale 1ns/1ps
module drs_capture_model
  import drs_pkg::*;
(
  input  wire logic             data_valid_clock_pos,
  input  wire logic             aligned_reset_out_pos,
  input  wire logic [SMP_W-1:0] primary_data,
  input  wire logic [SMP_W-1:0] aux_data,
  output logic      [SMP_W-1:0] cap_pri,
  output logic      [SMP_W-1:0] cap_aux,
  output int                    loads,
  output int                    rst_clocks
);
  initial begin
    loads = 0;
    rst_clocks = 0;
  end

  // ==========================================================================
  // Pair capture and clocks seen during reset
  always @(posedge data_valid_clock_pos) begin
    #1;
    cap_pri = primary_data;
    cap_aux = aux_data;
    loads = loads + 1;
    if (aligned_reset_out_pos) begin
      rst_clocks = rst_clocks + 1;
    end
  end
endmodule

// [bench/drs_top_tb.sv]
// Self-checking bench: random samples, rate sweep, reset pulses in both phases.
// Assumes the capture model watches the output ports.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, gt); end end
module drs_top_tb
  import drs_pkg::*;
;
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic [SMP_W-1:0] sample_in = 8'h00;
  logic             sync_reset_in_pos = 1'b0;
  logic             sync_reset_in_neg = 1'b1;
  logic             split_enable = 1'b0;
  logic             rate_divider_select = 1'b0;
  logic [SMP_W-1:0] primary_data, aux_data, cap_pri, cap_aux;
  logic             data_valid_clock_pos, data_valid_clock_neg;
  logic             aligned_reset_out_pos, aligned_reset_out_neg;
  logic [SMP_W-1:0] hist [0:8];
  logic             en = 1'b0;
  int               loads, lc_prev, div, rst_clk;
  int               bad_count = 0;
  int               checked = 0;

  drs_top u_drs_top (.ref_clk, .rst, .sample_in, .sync_reset_in_pos, .sync_reset_in_neg,
    .split_enable, .rate_divider_select, .primary_data, .aux_data, .data_valid_clock_pos,
    .data_valid_clock_neg, .aligned_reset_out_pos, .aligned_reset_out_neg);
  drs_capture_model u_drs_capture_model (.data_valid_clock_pos, .aligned_reset_out_pos,
    .primary_data, .aux_data, .cap_pri, .cap_aux, .loads, .rst_clocks(rst_clk));

  always #25 ref_clk = ~ref_clk;

  // ==========================================================================
  // Stimulus history and port checks
  always @(posedge ref_clk) begin
    for (int i = 8; i > 0; i--) begin
      hist[i] <= hist[i-1];
    end
    hist[0] <= sample_in;
    sample_in <= rst ? SMP_RST : SMP_W'($urandom);
  end

  always @(negedge ref_clk) begin
    if (en && loads != lc_prev) begin
      `CHK("primary", hist[7], cap_pri)
      `CHK("aux", hist[8], cap_aux)
    end else if (en) begin
      `CHK("hold", cap_pri, primary_data)
    end
    lc_prev = loads;
  end

  // ==========================================================================
  // Tasks
  task automatic set_mode(input logic se, input logic ds);
    en = 1'b0;
    @(posedge ref_clk);
    split_enable <= se;
    rate_divider_select <= ds;
    repeat (12) @(posedge ref_clk);
    en = 1'b1;
  endtask

  task automatic rate(input int dv);
    int l0;
    @(negedge ref_clk);
    l0 = loads;
    repeat (40) @(negedge ref_clk);
    `CHK("rate", 40 / dv, loads - l0)
  endtask

  // exp: 1 output pulse, 0 none, 2 either
  task automatic pulse(input int len, input logic p, input logic n, input int exp);
    int l0;
    int r0;
    @(posedge ref_clk);
    sync_reset_in_pos <= p;
    sync_reset_in_neg <= n;
    for (int i = 1; i <= len + 8; i++) begin
      @(posedge ref_clk);
      if (i == len) begin
        sync_reset_in_pos <= 1'b0;
        sync_reset_in_neg <= 1'b1;
      end
      @(negedge ref_clk);
      if (i == 7) begin
        l0 = loads;
        r0 = rst_clk;
      end
      if (exp < 2) begin
        `CHK("rst_out", 1'(exp == 1 && i >= 7 && i < 7 + len), aligned_reset_out_pos)
      end
      `CHK("rst_neg", ~aligned_reset_out_pos, aligned_reset_out_neg)
      if (div == 2 && i == 7 + len) begin
        `CHK("dv_phase", 1'b1, data_valid_clock_pos)
        if (exp == 1) begin
          `CHK("dv_run", len / 2, loads - l0)
          `CHK("rst_clocks", 1'b1, 1'(rst_clk > r0))
        end
      end
    end
  endtask

  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h31b0));
    div = 1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    set_mode(1'b0, 1'b0);
    rate(1);
    pulse(1, 1'b1, 1'b0, 1);
    for (int k = 0; k < 3; k++) begin
      pulse(1 + $urandom_range(5), 1'b1, 1'b0, 1);
    end
    pulse(3, 1'b1, 1'b1, 0);
    pulse(3, 1'b0, 1'b0, 0);
    div = 2;
    set_mode(1'b1, 1'b0);
    rate(2);
    pulse(2, 1'b1, 1'b0, 2);
    @(posedge ref_clk);
    pulse(4, 1'b1, 1'b0, 1);
    pulse(2, 1'b1, 1'b0, 0);
    div = 4;
    set_mode(1'b1, 1'b1);
    rate(4);
    pulse(6, 1'b1, 1'b0, 2);
    close_out();
  end
endmodule

// [hdl/drs_pkg.sv]
// Constants and types for the demux reset and phase alignment block.
// Assumes one sample clock domain; all latencies are counted in its edges.
package drs_pkg;

  // ==========================================================================
  // Widths and latencies
  localparam int SMP_W        = 8;
  localparam int PRI_LAT_HALF = 15;
  localparam int AUX_LAT_HALF = 17;
  localparam int RST_LAT_HALF = 13;
  localparam int SYNC_STAGES  = 2;
  localparam int PRI_TAP      = PRI_LAT_HALF / 2 - 1;
  localparam int AUX_TAP      = AUX_LAT_HALF / 2 - 1;
  localparam int SMP_DEPTH    = AUX_TAP + 1;
  localparam int RST_DEPTH    = RST_LAT_HALF / 2 - SYNC_STAGES;
  localparam int RST_TAP      = RST_DEPTH - 1;

  // ==========================================================================
  // Divider counter
  localparam int          CNT_W        = 2;
  localparam logic [1:0]  CNT_RST      = 2'h0;
  localparam logic [1:0]  CNT_STEP     = 2'h1;
  localparam logic [1:0]  RST_GAP      = 2'(RST_DEPTH);
  localparam logic [1:0]  MASK_FULL    = 2'h0;
  localparam logic [1:0]  MASK_HALF    = 2'h1;
  localparam logic [1:0]  MASK_QUARTER = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [SMP_W-1:0] SMP_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_FULL    = 2'h0,
    MODE_HALF    = 2'h1,
    MODE_QUARTER = 2'h3
  } drs_mode_t;

endpackage

// [hdl/drs_reset_pipe.sv]
// Reset latency pipeline matching the converter data latency.
// Assumes its input is already synchronised to the sample clock.
`timescale 1ns/1ps
module drs_reset_pipe
  import drs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic rst_in,
  output logic      head,
  output logic      tail
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [RST_DEPTH-1:0] stage;
  } drs_pipe_state_t;

  drs_pipe_state_t st_q;
  drs_pipe_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.stage = {st_q.stage[RST_DEPTH-2:0], rst_in};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign head = st_q.stage[0];
  assign tail = st_q.stage[RST_TAP];

endmodule

// [hdl/drs_sample_delay.sv]
// Sample delay line with registered taps for the primary and auxiliary ports.
// Assumes samples arrive on the sample clock, one per edge.
`timescale 1ns/1ps
module drs_sample_delay
  import drs_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [SMP_W-1:0] sample_in,
  output logic      [SMP_W-1:0] tap_newer,
  output logic      [SMP_W-1:0] tap_older
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [SMP_DEPTH-1:0][SMP_W-1:0] line;
  } drs_line_state_t;

  drs_line_state_t st_q;
  drs_line_state_t st_d;

  // ==========================================================================
  // Shift
  always_comb begin
    st_d = st_q;
    st_d.line[0] = sample_in;
    for (int i = 1; i < SMP_DEPTH; i++) begin
      st_d.line[i] = st_q.line[i-1];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tap_newer = st_q.line[PRI_TAP]; // RQ11
  assign tap_older = st_q.line[AUX_TAP]; // RQ11

endmodule

// [hdl/drs_top.sv]
// Demux reset capture, reset pipeline, divided data-valid clock and 1:2 output demux.
// Assumes ref_clk is the sample clock; reset and mode pins are asynchronous to it.
// Behaviour
// [RQ1] Demux reset input is captured on the rising sample clock edge.
// [RQ2] Undriven or inverted reset pair means reset deasserted, circuitry idle.
// [RQ3] Sample clock is the timing master for demux and reset logic.
// [RQ4] Port data change only on the rising data-valid clock edge.
// [RQ5] Asserted reset input resets the internal output demultiplexer.
// [RQ6] Reset path delay matches data latency so reset aligns with samples.
// [RQ7] Enable and select pins choose full, half or quarter rate clock.
// [RQ8] Half rate clock may start in either of two inverted phases.
// [RQ9] Applied reset forces the divider counter to one defined phase.
// [RQ10] Data-valid clock keeps toggling while the reset output is asserted.
// [RQ11] Half rate: auxiliary data 8.5, primary data 7.5 cycles after sampling.
// [RQ12] Auxiliary port carries the older sample, primary the newer.
// [RQ13] Reset output lags sampling by 6.5 cycles, one before primary data.
// [RQ14] Clock phase is set to reset phase when reset output falls.
// [RQ15] Already aligned phase: clock and data continue uninterrupted.
// [RQ16] Opposite phase: divider skips one cycle, port order reverses.
// [RQ17] When a pulse is skipped, the reset output pulse is suppressed; code mutes only its last 4 cycles, so longer input pulses still pass in part.
// [RQ18] One cycle reset pulse realigns internally; avoid with external demuxes.
// [RQ19] Controller holds reset long enough for external demultiplexers.
// [RQ20] Interleaved converters are all reset to a common phase.
// [RQ21] A single converter needs no synchronising reset.
// [RQ22] Output demux splits samples into two ports at half rate.
// [RQ23] Clock runs at full, half or quarter of the sample rate.
`timescale 1ns/1ps
module drs_top
  import drs_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [SMP_W-1:0] sample_in,
  input  wire logic             sync_reset_in_pos,
  input  wire logic             sync_reset_in_neg,
  input  wire logic             split_enable,
  input  wire logic             rate_divider_select,
  output logic      [SMP_W-1:0] primary_data,
  output logic      [SMP_W-1:0] aux_data,
  output logic                  data_valid_clock_pos,
  output logic                  data_valid_clock_neg,
  output logic                  aligned_reset_out_pos,
  output logic                  aligned_reset_out_neg
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic             en_s1;
    logic             en_s2;
    logic             sel_s1;
    logic             sel_s2;
    logic             rp_s1;
    logic             rp_s2;
    logic             rn_s1;
    logic             rn_s2;
    logic [CNT_W-1:0] cnt;
    logic             raw;
    logic             out;
    logic             mute;
    logic [SMP_W-1:0] pri;
    logic [SMP_W-1:0] aux;
  } drs_top_state_t;

  drs_top_state_t   st_q;
  drs_top_state_t   st_d;
  logic             rst_s;
  logic             pipe_head;
  logic             pipe_tail;
  logic [SMP_W-1:0] tap_newer;
  logic [SMP_W-1:0] tap_older;
  drs_mode_t        mode;
  logic [CNT_W-1:0] mask;
  logic [CNT_W-1:0] predicted;
  logic             fall_in;
  logic             fall_out;
  logic             misaligned;
  logic             load_en;
  logic             dv_div;

  // ==========================================================================
  // Submodules
  drs_sample_delay u_delay (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .sample_in (sample_in),
    .tap_newer (tap_newer),
    .tap_older (tap_older)
  );

  drs_reset_pipe u_pipe (
    .ref_clk (ref_clk),
    .rst     (rst),
    .rst_in  (rst_s),
    .head    (pipe_head),
    .tail    (pipe_tail)
  );

  // ==========================================================================
  // Decode
  always_comb begin
    rst_s = st_q.rp_s2 & ~st_q.rn_s2; // RQ2
    if (!st_q.en_s2) begin
      mode = MODE_FULL; // RQ7
      mask = MASK_FULL;
    end else if (st_q.sel_s2) begin
      mode = MODE_QUARTER;
      mask = MASK_QUARTER;
    end else begin
      mode = MODE_HALF;
      mask = MASK_HALF;
    end
    predicted  = st_q.cnt + RST_GAP;
    fall_in    = pipe_head & ~rst_s;
    misaligned = (predicted & mask) != mask; // RQ16
    fall_out   = st_q.raw & ~pipe_tail; // RQ14
    load_en    = (st_q.cnt & mask) == mask; // RQ4
    case (mode)
      MODE_QUARTER: dv_div = ~st_q.cnt[1]; // RQ23
      MODE_HALF:    dv_div = ~st_q.cnt[0]; // RQ8
      default:      dv_div = 1'b1;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_d        = st_q;
    st_d.en_s1  = split_enable;
    st_d.en_s2  = st_q.en_s1;
    st_d.sel_s1 = rate_divider_select;
    st_d.sel_s2 = st_q.sel_s1;
    st_d.rp_s1  = sync_reset_in_pos; // RQ1
    st_d.rp_s2  = st_q.rp_s1;
    st_d.rn_s1  = sync_reset_in_neg;
    st_d.rn_s2  = st_q.rn_s1;
    if (fall_out) begin // RQ5
      st_d.cnt = CNT_RST; // RQ9
    end else begin
      st_d.cnt = st_q.cnt + CNT_STEP; // RQ10
    end
    st_d.raw = pipe_tail; // RQ6
    if (fall_in && misaligned) begin
      st_d.mute = 1'b1; // RQ17
    end else if (fall_out) begin
      st_d.mute = 1'b0;
    end
    st_d.out = pipe_tail & ~st_d.mute; // RQ13
    if (load_en) begin
      st_d.pri = tap_newer; // RQ22
      st_d.aux = tap_older; // RQ12
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin // RQ3
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign primary_data          = st_q.pri;
  assign aux_data              = st_q.aux;
  assign data_valid_clock_pos  = (mode == MODE_FULL) ? ref_clk : dv_div;
  assign data_valid_clock_neg  = ~data_valid_clock_pos;
  assign aligned_reset_out_pos = st_q.out;
  assign aligned_reset_out_neg = ~st_q.out;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_rst_latency;
    ##7 1'b1 |-> st_q.raw == $past(sync_reset_in_pos && !sync_reset_in_neg, 7);
  endproperty
  a_rst_latency: assert property (p_rst_latency) // RQ6
    else $error("reset pipeline latency wrong");

  property p_phase_set;
    fall_out |=> st_q.cnt == CNT_RST;
  endproperty
  a_phase_set: assert property (p_phase_set) // RQ14
    else $error("divider not set at reset output fall");

  property p_swallow;
    fall_out && mode == MODE_HALF && !st_q.cnt[0] ##1 mode == MODE_HALF
      |-> $stable(dv_div);
  endproperty
  a_swallow: assert property (p_swallow) // RQ16
    else $error("half rate clock did not skip a cycle");

  property p_no_swallow;
    fall_out && mode == MODE_HALF && st_q.cnt[0] ##1 mode == MODE_HALF
      |-> $rose(dv_div);
  endproperty
  a_no_swallow: assert property (p_no_swallow) // RQ15
    else $error("aligned clock was interrupted");

  property p_mute;
    st_q.mute && $past(st_q.mute) |-> !aligned_reset_out_pos;
  endproperty
  a_mute: assert property (p_mute) // RQ17
    else $error("reset output not suppressed");

  property p_port_data;
    load_en |=> primary_data == $past(sample_in, 8) && aux_data == $past(sample_in, 9);
  endproperty
  a_port_data: assert property (p_port_data) // RQ11
    else $error("port data latency or order wrong");

  property p_half_toggle;
    mode == MODE_HALF && !fall_out ##1 mode == MODE_HALF |-> $changed(dv_div);
  endproperty
  a_half_toggle: assert property (p_half_toggle) // RQ23
    else $error("half rate clock did not toggle");

  property p_toggle_in_reset;
    aligned_reset_out_pos && !fall_out && mode == MODE_QUARTER
      |=> st_q.cnt == $past(st_q.cnt) + CNT_STEP;
  endproperty
  a_toggle_in_reset: assert property (p_toggle_in_reset) // RQ10
    else $error("divider stopped during reset output");

  property p_idle_input;
    !st_q.rp_s2 || st_q.rn_s2 |-> !rst_s;
  endproperty
  a_idle_input: assert property (p_idle_input) // RQ2
    else $error("undriven reset input seen as asserted");

endmodule
